// *** hw/fwlk_top.sv ***
// Flux-control configuration and motor-lock fault handling, reached over APB.
// Assumes lock-detect inputs come from control logic on sys_clk, one-cycle or level.
//
// Functional notes
// RULE1 - Torque-per-amp control follows its enable bit; bit resets to zero.
// RULE2 - Two-bit code selects modulation target 70, 80, 90 or 95 percent.
// RULE3 - Three-bit code caps weakening current; zero means circular limit only.
// RULE4 - Field-weakening control follows its enable bit; bit resets to zero.
// RULE5 - Retry code selects 100ms, 500ms, 1s, then 2s to 14s.
// RULE6 - Mode 0: lock latches fault, fault_out_n low until software clears.
// RULE7 - Mode 1: lock fault clears itself after the retry time.
// RULE8 - Mode 2: lock is only reported, no fault action.
// RULE9 - Mode 3: no lock detection at all.
// RULE10 - Each lock source takes part only when its own enable is set.
// RULE11 - Reserved flux bits read zero; writes to them do nothing.
// RULE12 - Report-only mode flags status while motor runs and fault stays off.
`timescale 1ns/1ns
module fwlk_top
  import fwlk_pkg::*;
#(
  parameter int unsigned MS_CYCLES = FWLK_MS_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic overspeed_lock_det,
  input wire logic hall_invalid_lock_det,
  input wire logic no_motor_lock_det,
  output logic torque_per_amp_enable,
  output logic field_weaken_enable,
  output logic [6:0] mod_index_pct,
  output logic [6:0] field_weaken_current_cap,
  output logic cap_circular_only,
  output logic fault_out_n,
  output logic motor_stop,
  output logic lock_reported,
  output logic irq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Two-stage release of the asynchronous reset.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  typedef enum {LK_IDLE, LK_LATCHED, LK_RETRY} fwlk_lock_state_e;

  fwlk_flux_s flux_ff;
  fwlk_lock_s lock_cfg_ff;
  fwlk_lock_src_s lock_en_ff;
  logic [FWLK_IRQ_BITS-1:0] irq_stat_ff;
  logic [FWLK_IRQ_BITS-1:0] irq_mask_ff;
  logic [FWLK_IRQ_BITS-1:0] irq_set;
  logic [31:0] wmask;
  logic [31:0] nxt_prdata;
  logic [31:0] flux_word;
  logic [31:0] lock_word;
  logic [31:0] nxt_flux_word;
  logic [31:0] nxt_lock_word;
  logic [31:0] en_word;
  logic [31:0] nxt_en_word;
  logic [31:0] state_word;
  logic addr_ok;
  logic wr_acc;
  fwlk_lock_state_e lk_state_ff;
  logic report_ff;
  logic [31:0] prescale_ff;
  logic [13:0] ms_left_ff;

  // Byte lanes expanded into a bit mask.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{pstrb[gi]}};
    end
  endgenerate

  // Known offsets; anything else answers with an error and reads zero.
  always_comb
  begin
    unique case (paddr)
      FWLK_OFS_FLUX, FWLK_OFS_LOCK, FWLK_OFS_LOCK_EN, FWLK_OFS_IRQ_STAT, FWLK_OFS_IRQ_MASK, FWLK_OFS_STATE:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // Zero wait states; error only in the access phase of an unmapped offset.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_acc = psel & penable & pwrite & addr_ok;

  // Register words as software sees them.
  assign flux_word = {25'h0, flux_ff};
  assign lock_word = lock_cfg_ff;
  assign en_word = {5'h0, lock_en_ff, 24'h0};
  assign state_word = {24'h0, report_ff, lk_state_ff == LK_RETRY, lk_state_ff != LK_IDLE, 3'h0,
                       lock_cfg_ff.lock_response_mode};
  assign nxt_flux_word = (flux_word & ~wmask) | (pwdata & wmask);
  assign nxt_lock_word = (lock_word & ~wmask) | (pwdata & wmask);
  assign nxt_en_word = (en_word & ~wmask) | (pwdata & wmask);

  // Read mux, captured in the setup phase so data is stable in the access phase.
  always_comb
  begin
    unique case (paddr)
      FWLK_OFS_FLUX: nxt_prdata = flux_word; // RULE11
      FWLK_OFS_LOCK: nxt_prdata = lock_word;
      FWLK_OFS_LOCK_EN: nxt_prdata = en_word;
      FWLK_OFS_IRQ_STAT: nxt_prdata = {29'h0, irq_stat_ff};
      FWLK_OFS_IRQ_MASK: nxt_prdata = {29'h0, irq_mask_ff};
      FWLK_OFS_STATE: nxt_prdata = state_word;
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Read data register.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Software settings; flux stores only bits 6..0, so its reserved bits stay zero.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      flux_ff <= fwlk_flux_s'(FWLK_RST_FLUX[FWLK_FLUX_USED_MSB:0]); // RULE1 RULE4
      lock_cfg_ff <= fwlk_lock_s'(FWLK_RST_LOCK);
      lock_en_ff <= fwlk_lock_src_s'(FWLK_RST_EN);
      irq_mask_ff <= FWLK_RST_IRQ;
    end
    else
    begin
      if (wr_acc && paddr == FWLK_OFS_FLUX)
      begin
        flux_ff <= fwlk_flux_s'(nxt_flux_word[FWLK_FLUX_USED_MSB:0]); // RULE11
      end
      if (wr_acc && paddr == FWLK_OFS_LOCK)
      begin
        lock_cfg_ff <= fwlk_lock_s'(nxt_lock_word);
      end
      if (wr_acc && paddr == FWLK_OFS_LOCK_EN)
      begin
        lock_en_ff <= fwlk_lock_src_s'(nxt_en_word[FWLK_EN_OVERSPEED_BIT:FWLK_EN_NOMOTOR_BIT]);
      end
      if (wr_acc && paddr == FWLK_OFS_IRQ_MASK && pstrb[0])
      begin
        irq_mask_ff <= pwdata[FWLK_IRQ_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flux control outputs
  // ----------------------------------------------------------------
  // Decoded flux settings, registered.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      torque_per_amp_enable <= 1'b0;
      field_weaken_enable <= 1'b0;
      mod_index_pct <= 7'h00;
      field_weaken_current_cap <= 7'h00;
      cap_circular_only <= 1'b1;
    end
    else
    begin
      torque_per_amp_enable <= flux_ff.torque_per_amp_enable; // RULE1
      field_weaken_enable <= flux_ff.field_weaken_enable; // RULE4
      mod_index_pct <= fwlk_mod_pct(flux_ff.mod_index_code); // RULE2
      field_weaken_current_cap <= fwlk_cap_pct(flux_ff.field_weaken_current_cap); // RULE3
      cap_circular_only <= flux_ff.field_weaken_current_cap == 3'h0; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // Motor-lock handling
  // ----------------------------------------------------------------
  fwlk_mode_e mode;
  logic lock_hit;
  logic fault_clr;
  logic ms_tick;
  logic retry_done;

  assign mode = fwlk_mode_e'(lock_cfg_ff.lock_response_mode);
  // Enabled sources only, and nothing at all when detection is off.
  assign lock_hit = (mode != FWLK_MODE_OFF) && // RULE9
                    ((overspeed_lock_det & lock_en_ff.overspeed) | // RULE10
                     (hall_invalid_lock_det & lock_en_ff.hall_invalid) |
                     (no_motor_lock_det & lock_en_ff.no_motor));
  // Software clears a latched fault by writing one to the fault status bit.
  assign fault_clr = wr_acc && paddr == FWLK_OFS_IRQ_STAT && pstrb[0] && pwdata[FWLK_IRQ_FAULT_BIT];
  assign ms_tick = prescale_ff == 32'(MS_CYCLES - 1);
  assign retry_done = (lk_state_ff == LK_RETRY) && ms_tick && (ms_left_ff <= 14'h0001);

  // Retry timer: millisecond prescaler and milliseconds left, both reloaded outside a retry wait.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      prescale_ff <= 32'h0000_0000;
      ms_left_ff <= 14'h0000;
    end
    else if (lk_state_ff != LK_RETRY)
    begin
      prescale_ff <= 32'h0000_0000;
      ms_left_ff <= fwlk_retry_ms(lock_cfg_ff.lock_retry_time); // RULE5
    end
    else if (ms_tick)
    begin
      prescale_ff <= 32'h0000_0000;
      ms_left_ff <= ms_left_ff - 14'h0001;
    end
    else
    begin
      prescale_ff <= prescale_ff + 32'h0000_0001;
    end
  end

  // Fault state: latched waits for software, auto waits out the retry time.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      lk_state_ff <= LK_IDLE;
    end
    else
    begin
      unique case (lk_state_ff)
        LK_IDLE:
          if (lock_hit && mode == FWLK_MODE_LATCH)
          begin
            lk_state_ff <= LK_LATCHED; // RULE6
          end
          else if (lock_hit && mode == FWLK_MODE_AUTO)
          begin
            lk_state_ff <= LK_RETRY; // RULE7
          end
        LK_LATCHED:
          if (fault_clr && !lock_hit)
          begin
            lk_state_ff <= LK_IDLE; // RULE6
          end
        LK_RETRY:
          if (fault_clr || retry_done)
          begin
            lk_state_ff <= LK_IDLE; // RULE7
          end
      endcase
    end
  end

  // Report-only indication, held until software clears the detect status.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      report_ff <= 1'b0;
    end
    else if (lock_hit && mode == FWLK_MODE_REPORT)
    begin
      report_ff <= 1'b1; // RULE8 RULE12
    end
    else if (wr_acc && paddr == FWLK_OFS_IRQ_STAT && pstrb[0] && pwdata[FWLK_IRQ_DETECT_BIT])
    begin
      report_ff <= 1'b0;
    end
  end

  // Fault pin and motor stop follow the fault state only, never report-only mode.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      fault_out_n <= 1'b1;
      motor_stop <= 1'b0;
      lock_reported <= 1'b0;
    end
    else
    begin
      fault_out_n <= lk_state_ff == LK_IDLE; // RULE6 RULE12
      motor_stop <= lk_state_ff != LK_IDLE; // RULE8
      lock_reported <= report_ff; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_set[FWLK_IRQ_DETECT_BIT] = lock_hit;
  assign irq_set[FWLK_IRQ_FAULT_BIT] = lock_hit && (mode == FWLK_MODE_LATCH || mode == FWLK_MODE_AUTO);
  assign irq_set[FWLK_IRQ_AUTOCLR_BIT] = retry_done && !fault_clr;

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      irq_stat_ff <= FWLK_RST_IRQ;
    end
    else if (wr_acc && paddr == FWLK_OFS_IRQ_STAT && pstrb[0])
    begin
      irq_stat_ff <= (irq_stat_ff & ~pwdata[FWLK_IRQ_BITS-1:0]) | irq_set;
    end
    else
    begin
      irq_stat_ff <= irq_stat_ff | irq_set;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

endmodule : fwlk_top

// *** shared/fwlk_pkg.sv ***
// Package of the flux-control and motor-lock fault block: register map, fields, resets, timing.
// Assumes a single 125 MHz system clock and an APB register bus with 32-bit data.
package fwlk_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FWLK_OFS_FLUX = 8'h4c;
  localparam logic [7:0] FWLK_OFS_LOCK = 8'h50;
  localparam logic [7:0] FWLK_OFS_LOCK_EN = 8'h54;
  localparam logic [7:0] FWLK_OFS_IRQ_STAT = 8'h58;
  localparam logic [7:0] FWLK_OFS_IRQ_MASK = 8'h5c;
  localparam logic [7:0] FWLK_OFS_STATE = 8'h60;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FWLK_FLUX_MAX_TORQUE_PER_AMP_BIT = 6;
  localparam int FWLK_FLUX_REF_LSB = 4;
  localparam int FWLK_FLUX_CAP_LSB = 1;
  localparam int FWLK_FLUX_FW_BIT = 0;
  localparam int FWLK_FLUX_USED_MSB = 6;
  localparam int FWLK_LOCK_RETRY_LSB = 2;
  localparam int FWLK_LOCK_MODE_LSB = 0;
  localparam int FWLK_EN_OVERSPEED_BIT = 26;
  localparam int FWLK_EN_HALL_BIT = 25;
  localparam int FWLK_EN_NOMOTOR_BIT = 24;
  localparam int FWLK_IRQ_DETECT_BIT = 0;
  localparam int FWLK_IRQ_FAULT_BIT = 1;
  localparam int FWLK_IRQ_AUTOCLR_BIT = 2;
  localparam int FWLK_IRQ_BITS = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FWLK_RST_FLUX = 32'h0000_0000;
  localparam logic [31:0] FWLK_RST_LOCK = 32'h0000_0000;
  localparam logic [2:0] FWLK_RST_EN = 3'h0;
  localparam logic [2:0] FWLK_RST_IRQ = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FWLK_CLK_PERIOD_NS = 8;
  localparam int FWLK_MS_NS = 1000000;
  localparam int FWLK_MS_CYCLES = FWLK_MS_NS / FWLK_CLK_PERIOD_NS;
  localparam logic [13:0] FWLK_RETRY_MS_0 = 14'h0064;
  localparam logic [13:0] FWLK_RETRY_MS_1 = 14'h01f4;
  localparam logic [13:0] FWLK_RETRY_MS_STEP = 14'h03e8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FWLK_MODE_LATCH = 2'h0,
    FWLK_MODE_AUTO = 2'h1,
    FWLK_MODE_REPORT = 2'h2,
    FWLK_MODE_OFF = 2'h3
  } fwlk_mode_e;

  typedef struct packed {
    logic torque_per_amp_enable;
    logic [1:0] mod_index_code;
    logic [2:0] field_weaken_current_cap;
    logic field_weaken_enable;
  } fwlk_flux_s;

  typedef struct packed {
    logic [25:0] spare;
    logic [3:0] lock_retry_time;
    logic [1:0] lock_response_mode;
  } fwlk_lock_s;

  typedef struct packed {
    logic overspeed;
    logic hall_invalid;
    logic no_motor;
  } fwlk_lock_src_s;

  // Modulation-index target in percent for a two-bit code.
  function automatic logic [6:0] fwlk_mod_pct(input logic [1:0] code);
    unique case (code)
      2'h0: fwlk_mod_pct = 7'h46;
      2'h1: fwlk_mod_pct = 7'h50;
      2'h2: fwlk_mod_pct = 7'h5a;
      2'h3: fwlk_mod_pct = 7'h5f;
    endcase
  endfunction : fwlk_mod_pct

  // Field-weakening current cap in percent of the current limit; zero means circular limit only.
  function automatic logic [6:0] fwlk_cap_pct(input logic [2:0] code);
    if (code == 3'h0)
    begin
      fwlk_cap_pct = 7'h00;
    end
    else
    begin
      fwlk_cap_pct = 7'(7'd90 - 7'd10 * 7'(code));
    end
  endfunction : fwlk_cap_pct

  // Retry time in milliseconds for a four-bit code.
  function automatic logic [13:0] fwlk_retry_ms(input logic [3:0] code);
    if (code == 4'h0)
    begin
      fwlk_retry_ms = FWLK_RETRY_MS_0;
    end
    else if (code == 4'h1)
    begin
      fwlk_retry_ms = FWLK_RETRY_MS_1;
    end
    else
    begin
      fwlk_retry_ms = 14'(FWLK_RETRY_MS_STEP * 14'(code - 4'h1));
    end
  endfunction : fwlk_retry_ms

endpackage : fwlk_pkg

// *** tb/fwlk_top_properties.sv ***
// Checker of the flux-control and lock block, watching only the top ports.
// Assumes it is bound into fwlk_top and that the bench reads flux config at rest.
`timescale 1ns/1ns
module fwlk_checker
  import fwlk_pkg::*;
#(
  parameter int unsigned MS_CYCLES = FWLK_MS_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic overspeed_lock_det,
  input wire logic hall_invalid_lock_det,
  input wire logic no_motor_lock_det,
  input wire logic torque_per_amp_enable,
  input wire logic field_weaken_enable,
  input wire logic [6:0] mod_index_pct,
  input wire logic [6:0] field_weaken_current_cap,
  input wire logic cap_circular_only,
  input wire logic fault_out_n,
  input wire logic motor_stop,
  input wire logic lock_reported,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Decodes and properties
  // ----------------------------------------------------------------
  localparam logic [6:0] MOD_T [4] = '{7'h46, 7'h50, 7'h5a, 7'h5f};
  localparam logic [6:0] CAP_T [8] = '{7'h00, 7'h50, 7'h46, 7'h3c, 7'h32, 7'h28, 7'h1e, 7'h14};
  logic acc;
  logic rd_flux;
  logic mapped;
  logic wr_clr;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Access-phase decodes; a clear is a write to status or mask.
  assign acc = psel && penable;
  assign rd_flux = acc && !pwrite && (paddr == FWLK_OFS_FLUX);
  assign mapped = paddr inside {FWLK_OFS_FLUX, FWLK_OFS_LOCK, FWLK_OFS_LOCK_EN, FWLK_OFS_IRQ_STAT,
                                FWLK_OFS_IRQ_MASK, FWLK_OFS_STATE};
  assign wr_clr = acc && pwrite && (paddr == FWLK_OFS_IRQ_STAT || paddr == FWLK_OFS_IRQ_MASK);
  a_apb_err_map: assert property (acc |-> pready && (pslverr == !mapped))
    else $error("pready or pslverr wrong in access phase");
  a_tpa_follows: assert property (rd_flux |-> torque_per_amp_enable == prdata[6])
    else $error("torque per amp enable differs from register");
  a_fw_follows: assert property (rd_flux |-> field_weaken_enable == prdata[0])
    else $error("field weaken enable differs from register");
  a_mod_target: assert property (rd_flux |-> mod_index_pct == MOD_T[prdata[5:4]])
    else $error("modulation target wrong for code");
  a_cap_value: assert property (rd_flux |-> field_weaken_current_cap == CAP_T[prdata[3:1]])
    else $error("current cap wrong for code");
  a_cap_circular: assert property (cap_circular_only == (field_weaken_current_cap == 7'h00))
    else $error("circular flag disagrees with cap");
  a_flux_rsv_zero: assert property (rd_flux |-> prdata[31:7] == 25'h0)
    else $error("reserved flux bits not zero");
  a_stop_fault: assert property ($rose(motor_stop) |-> ##[0:2] !fault_out_n)
    else $error("fault output not low with motor stop");
  a_report_only: assert property ($rose(lock_reported) |-> fault_out_n && !motor_stop)
    else $error("report only lock took fault action");
  a_report_clear: assert property ($fell(lock_reported) |-> $past(wr_clr) || $past(wr_clr, 2))
    else $error("lock report dropped without clear");
  a_irq_clear: assert property ($fell(irq) |-> $past(wr_clr) || $past(wr_clr, 2))
    else $error("irq dropped without status or mask write");
  c_flux_read: cover property (rd_flux);
  c_fault_set: cover property ($fell(fault_out_n));
  c_report_set: cover property ($rose(lock_reported));
endmodule : fwlk_checker
bind fwlk_top fwlk_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .overspeed_lock_det(overspeed_lock_det),
  .hall_invalid_lock_det(hall_invalid_lock_det), .no_motor_lock_det(no_motor_lock_det),
  .torque_per_amp_enable(torque_per_amp_enable), .field_weaken_enable(field_weaken_enable),
  .mod_index_pct(mod_index_pct), .field_weaken_current_cap(field_weaken_current_cap),
  .cap_circular_only(cap_circular_only), .fault_out_n(fault_out_n), .motor_stop(motor_stop),
  .lock_reported(lock_reported), .irq(irq));

// *** tb/test_fwlk_top.sv ***
// Self-checking bench of the flux-control and lock block over APB.
// Assumes a four-cycle millisecond so retry times stay short.
`timescale 1ns/1ns
module test_fwlk_top
  import fwlk_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int MS = 4;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] det = 3'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tpa, fwe, circ, fault_out_n, stop, rep, irq;
  logic [6:0] mod_pct, cap_pct;
  logic [31:0] rd_data, v;
  logic rd_err;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] ofs [6] = '{FWLK_OFS_FLUX, FWLK_OFS_LOCK, FWLK_OFS_LOCK_EN, FWLK_OFS_IRQ_STAT,
                          FWLK_OFS_IRQ_MASK, FWLK_OFS_STATE};
  logic [3:0] rc [3] = '{4'h0, 4'h1, 4'h3};
  fwlk_top #(.MS_CYCLES(MS)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overspeed_lock_det(det[2]), .hall_invalid_lock_det(det[1]),
    .no_motor_lock_det(det[0]), .torque_per_amp_enable(tpa), .field_weaken_enable(fwe),
    .mod_index_pct(mod_pct), .field_weaken_current_cap(cap_pct), .cap_circular_only(circ),
    .fault_out_n(fault_out_n), .motor_stop(stop), .lock_reported(rep), .irq(irq));
  // Free-running clock of 8 ns and a cycle ceiling against hangs.
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected values, worked out from the field codes.
  function automatic logic [6:0] exp_mod(input logic [1:0] c);
    return c[1] ? (c[0] ? 7'h5f : 7'h5a) : (c[0] ? 7'h50 : 7'h46);
  endfunction : exp_mod
  function automatic logic [6:0] exp_cap(input logic [2:0] c);
    return (c == 3'h0) ? 7'h00 : 7'(8'd90 - 8'd10 * 8'(c));
  endfunction : exp_cap
  function automatic int exp_retry(input logic [3:0] c);
    return MS * ((c == 4'h0) ? 100 : (c == 4'h1) ? 500 : 1000 * (int'(c) - 1));
  endfunction : exp_retry
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    chk("pready", pready, 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One-cycle pulse on a single lock source.
  task automatic pulse(input int k);
    @(posedge sys_clk);
    det <= 3'(1 << k);
    @(posedge sys_clk);
    det <= 3'h0;
    tick(3);
  endtask : pulse
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    v = $urandom(41);
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    tick(4);
    // Every register starts at zero.
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", rd_data, 32'h0);
    end
    // Every flux code with random reserved bits.
    for (int i = 0; i < 128; i++)
    begin
      v = ($urandom & 32'hffff_ff80) | i;
      apb(1'b1, FWLK_OFS_FLUX, v);
      apb(1'b0, FWLK_OFS_FLUX, 32'h0);
      chk("flux readback", rd_data, v & 32'h7f);
      chk("tpa enable", tpa, v[6]);
      chk("fw enable", fwe, v[0]);
      chk("mod pct", mod_pct, exp_mod(v[5:4]));
      chk("cap pct", cap_pct, exp_cap(v[3:1]));
      chk("circular", circ, v[3:1] == 3'h0);
    end
    // A write with byte lane 0 off leaves the flux fields as they were.
    pstrb <= 4'he;
    apb(1'b1, FWLK_OFS_FLUX, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, FWLK_OFS_FLUX, 32'h0);
    chk("flux strobe", rd_data, v & 32'h7f);
    // Lock config storage, mode in the state register, unmapped refusal.
    v = $urandom;
    apb(1'b1, FWLK_OFS_LOCK, v);
    apb(1'b0, FWLK_OFS_LOCK, 32'h0);
    chk("lock readback", rd_data, v);
    apb(1'b0, FWLK_OFS_STATE, 32'h0);
    chk("state mode", rd_data[1:0], v[1:0]);
    apb(1'b1, 8'h40, 32'hffff_ffff);
    chk("unmapped err", rd_err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", {rd_err, rd_data}, {1'b1, 32'h0});
    apb(1'b1, FWLK_OFS_LOCK_EN, 32'h0700_0000);
    apb(1'b1, FWLK_OFS_IRQ_MASK, 32'h7);
    // Latched mode holds past the 100 ms retry time of code 0 until cleared.
    apb(1'b1, FWLK_OFS_LOCK, 32'h0);
    pulse(0);
    chk("latch fault", {fault_out_n, stop, irq}, 3'b011);
    tick(600);
    chk("latch held", fault_out_n, 1'b0);
    apb(1'b1, FWLK_OFS_IRQ_STAT, 32'h2);
    tick(3);
    chk("latch clear", {fault_out_n, stop}, 2'b10);
    apb(1'b1, FWLK_OFS_IRQ_STAT, 32'h7);
    tick(2);
    chk("irq clear", irq, 1'b0);
    // Auto-clear after the retry time for several codes.
    foreach (rc[j])
    begin
      apb(1'b1, FWLK_OFS_LOCK, {26'h0, rc[j], 2'h1});
      pulse(1);
      chk("auto fault", fault_out_n, 1'b0);
      n = 3;
      while (fault_out_n !== 1'b1 && n < 9000)
      begin
        tick(1);
        n++;
      end
      chk("retry time", n >= exp_retry(rc[j]) - 1 && n <= exp_retry(rc[j]) + 6, 1'b1);
      apb(1'b0, FWLK_OFS_IRQ_STAT, 32'h0);
      chk("auto status", rd_data[2], 1'b1);
      apb(1'b1, FWLK_OFS_IRQ_STAT, 32'h7);
    end
    // Report-only with the interrupt masked, then unmasked, then cleared.
    apb(1'b1, FWLK_OFS_IRQ_MASK, 32'h0);
    apb(1'b1, FWLK_OFS_LOCK, 32'h2);
    pulse(2);
    chk("report", {rep, fault_out_n, stop, irq}, 4'b1100);
    apb(1'b0, FWLK_OFS_IRQ_STAT, 32'h0);
    chk("report status", rd_data[0], 1'b1);
    apb(1'b1, FWLK_OFS_IRQ_MASK, 32'h7);
    tick(2);
    chk("irq unmasked", irq, 1'b1);
    apb(1'b1, FWLK_OFS_IRQ_STAT, 32'h1);
    tick(2);
    chk("report clear", {rep, irq}, 2'b00);
    // A disabled source is ignored while the others still count.
    apb(1'b1, FWLK_OFS_LOCK_EN, 32'h0300_0000);
    pulse(2);
    chk("source off", rep, 1'b0);
    pulse(0);
    chk("source on", rep, 1'b1);
    apb(1'b1, FWLK_OFS_IRQ_STAT, 32'h7);
    apb(1'b1, FWLK_OFS_LOCK_EN, 32'h0700_0000);
    // Detection off: no source leaves a trace.
    apb(1'b1, FWLK_OFS_LOCK, 32'h3);
    for (int k = 0; k < 3; k++)
      pulse(k);
    chk("off outputs", {rep, fault_out_n, stop}, 3'b010);
    apb(1'b0, FWLK_OFS_IRQ_STAT, 32'h0);
    chk("off status", rd_data, 32'h0);
    test_done();
  end
endmodule : test_fwlk_top
